// *** logic/ring_phase_status_supervisor.sv ***
// ring phase status supervisor: phase tracking, checks, telegram monitor, indicator
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps

module ring_phase_status_supervisor #(
  parameter int BLINK_CYCLES = ring_sup_pkg::BLINK_CYCLES
) (
  input  wire logic                  clk_sys,               // 100 mhz clock
  input  wire logic                  resetn,                // async reset, active low
  input  wire logic [5:0]            address,               // avalon byte address
  input  wire logic                  read,                  // avalon read
  input  wire logic                  write,                 // avalon write
  input  wire logic [31:0]           writedata,             // avalon write data
  output logic      [31:0]           readdata,              // avalon read data
  output logic                       waitrequest,           // avalon wait
  input  wire ring_sup_pkg::ring_evt_t ring_evt,            // telegram events, same clock
  input  wire logic [7:0]            station_addr_pins,     // address switch pins
  input  wire logic                  rate_select_switch,    // high = maximum rate
  output logic      [4:0]            ring_status_indicator, // indicator code
  output logic                       ring_status_dp,        // decimal point
  output logic                       ring_status_blank,     // blanks indicator when flashing
  output logic                       power_stage_en         // drive power stage release
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [8:0] pin_meta_reg;
  logic [8:0] pin_sync_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_meta_reg <= 9'h1ff;
      pin_sync_reg <= 9'h1ff;
    end else begin
      pin_meta_reg <= {rate_select_switch, station_addr_pins};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire       rate_high = pin_sync_reg[8];
  wire       addr_zero = (pin_sync_reg[7:0] == 8'h00);

  // ************************************************************
  // register bus
  // ************************************************************
  logic [4:0]  ctrl_reg;
  logic [15:0] present_reg;
  logic [15:0] inrange_reg;
  logic [15:0] req3_reg;
  logic [15:0] req4_reg;
  logic [15:0] list3_reg;
  logic [15:0] list3_next;
  logic [15:0] list4_reg;
  logic [15:0] list4_next;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] status_w;
  logic [31:0] rd_mux;

  wire req      = read | write;
  wire wr_fire  = write & ~wait_reg;
  wire sel_ctrl = (address == ring_sup_pkg::OFS_CTRL);
  wire sel_pres = (address == ring_sup_pkg::OFS_PRESENT);
  wire sel_rng  = (address == ring_sup_pkg::OFS_INRANGE);
  wire sel_req3 = (address == ring_sup_pkg::OFS_REQ3);
  wire sel_req4 = (address == ring_sup_pkg::OFS_REQ4);
  wire err_clr  = wr_fire & sel_ctrl & writedata[ring_sup_pkg::CTRL_ERR_CLR];

  assign rd_mux =
    sel_ctrl ? {27'h0000000, ctrl_reg} :
    (address == ring_sup_pkg::OFS_STATUS) ? status_w :
    sel_pres ? {16'h0000, present_reg} :
    sel_rng  ? {16'h0000, inrange_reg} :
    sel_req3 ? {16'h0000, req3_reg} :
    sel_req4 ? {16'h0000, req4_reg} :
    (address == ring_sup_pkg::OFS_LIST3) ? {16'h0000, list3_reg} :
    (address == ring_sup_pkg::OFS_LIST4) ? {16'h0000, list4_reg} :
    32'h00000000;

  // one wait cycle per access; unmapped reads give zero, writes are dropped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else if (req && wait_reg) begin
      wait_reg  <= 1'b0;
      rdata_reg <= rd_mux;
    end else begin
      wait_reg  <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg    <= ring_sup_pkg::CTRL_RST;
      present_reg <= ring_sup_pkg::SLOT_RST;
      inrange_reg <= ring_sup_pkg::SLOT_RST;
      req3_reg    <= ring_sup_pkg::REQ_RST;
      req4_reg    <= ring_sup_pkg::REQ_RST;
    end else if (wr_fire) begin
      if (sel_ctrl) ctrl_reg <= writedata[ring_sup_pkg::CTRL_W-1:0];
      if (sel_pres) present_reg <= writedata[15:0];
      if (sel_rng)  inrange_reg <= writedata[15:0];
      if (sel_req3) req3_reg <= writedata[15:0];
      if (sel_req4) req4_reg <= writedata[15:0];
    end
  end

  assign readdata    = rdata_reg;
  assign waitrequest = wait_reg;

  // ************************************************************
  // parameter checks before phases 3 and 4
  // ************************************************************
  // only presence and limit flags count; functional sense is not judged
  wire [15:0] slot_ok = present_reg & inrange_reg;
  wire [15:0] bad3    = req3_reg & ~slot_ok;
  wire [15:0] bad4    = req4_reg & ~slot_ok;

  // ************************************************************
  // phase tracking
  // ************************************************************
  ring_sup_pkg::phase_state_t state_reg;
  ring_sup_pkg::phase_state_t state_next;
  logic [2:0] cur_num;
  logic       inv_req;
  logic       prog_req;
  logic       regr_req;

  always_comb begin
    unique case (state_reg)
      ring_sup_pkg::ST_PH1: cur_num = 3'h1;
      ring_sup_pkg::ST_PH2: cur_num = 3'h2;
      ring_sup_pkg::ST_PH3: cur_num = 3'h3;
      ring_sup_pkg::ST_PH4: cur_num = 3'h4;
      default:              cur_num = 3'h0;
    endcase
  end

  wire [2:0] req_ph   = ring_evt.mst_phase;
  wire       mst_v    = ring_evt.mst_valid;
  wire       waiting  = (state_reg == ring_sup_pkg::ST_WAIT);
  wire       step_up  = mst_v & ~waiting & (req_ph == cur_num + 3'h1);
  wire       blocked  = step_up & (((req_ph == 3'h3) & (bad3 != 16'h0000)) |
                                   ((req_ph == 3'h4) & (bad4 != 16'h0000)));

  always_comb begin
    state_next = state_reg;
    inv_req    = 1'b0;
    prog_req   = 1'b0;
    regr_req   = 1'b0;
    if (mst_v) begin
      if (req_ph > ring_sup_pkg::PHASE_MAX) begin
        inv_req = 1'b1;
      end else if (waiting) begin
        if (req_ph == 3'h0) state_next = ring_sup_pkg::ST_PH0;
        else prog_req = 1'b1;
      end else if (step_up) begin
        if (!blocked) begin
          state_next = ring_sup_pkg::phase_state_t'(state_reg + 3'h1);
        end
      end else if (req_ph > cur_num) begin
        prog_req = 1'b1;
      end else if (req_ph < cur_num) begin
        // a restart from phase 0 is legal, any other step back is refused
        if (req_ph == 3'h0) state_next = ring_sup_pkg::ST_PH0;
        else regr_req = 1'b1;
      end
    end
  end

  // the list follows the attempt and shrinks as entries are corrected
  assign list3_next = (step_up && req_ph == 3'h3) ? bad3 : (list3_reg & ~slot_ok);
  assign list4_next = (step_up && req_ph == 3'h4) ? bad4 : (list4_reg & ~slot_ok);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ring_sup_pkg::ST_WAIT;
      list3_reg <= ring_sup_pkg::SLOT_RST;
      list4_reg <= ring_sup_pkg::SLOT_RST;
    end else begin
      state_reg <= state_next;
      list3_reg <= list3_next;
      list4_reg <= list4_next;
    end
  end

  // ************************************************************
  // telegram monitor and latched errors
  // ************************************************************
  wire mon_on   = (state_reg == ring_sup_pkg::ST_PH3) |
                  (state_reg == ring_sup_pkg::ST_PH4);
  wire mdt_fail = ring_evt.mdt_miss | ring_evt.mdt_len_err | ring_evt.mdt_crc_err;

  logic mst_prev_reg;
  logic mdt_prev_reg;
  logic mst_err_reg;
  logic mdt_err_reg;
  logic inv_err_reg;
  logic prog_err_reg;
  logic regr_err_reg;

  // each kind of telegram keeps its own pending miss
  wire mst_twice = mon_on & ring_evt.mst_miss & mst_prev_reg;
  wire mdt_twice = mon_on & mdt_fail & mdt_prev_reg;

  // a new error in the clearing cycle survives the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mst_prev_reg <= 1'b0;
      mdt_prev_reg <= 1'b0;
      mst_err_reg  <= 1'b0;
      mdt_err_reg  <= 1'b0;
      inv_err_reg  <= 1'b0;
      prog_err_reg <= 1'b0;
      regr_err_reg <= 1'b0;
    end else begin
      if (!mon_on || mst_v) mst_prev_reg <= 1'b0;
      else if (ring_evt.mst_miss) mst_prev_reg <= 1'b1;
      if (!mon_on || ring_evt.mdt_ok) mdt_prev_reg <= 1'b0;
      else if (mdt_fail) mdt_prev_reg <= 1'b1;
      mst_err_reg  <= mst_twice | (mst_err_reg & ~err_clr);
      mdt_err_reg  <= mdt_twice | (mdt_err_reg & ~err_clr);
      inv_err_reg  <= inv_req   | (inv_err_reg & ~err_clr);
      prog_err_reg <= prog_req  | (prog_err_reg & ~err_clr);
      regr_err_reg <= regr_req  | (regr_err_reg & ~err_clr);
    end
  end

  // ************************************************************
  // indicator
  // ************************************************************
  logic [24:0] blink_cnt_reg;
  logic        blink_reg;
  logic [4:0]  code_w;
  logic [4:0]  code_reg;
  logic        dp_reg;
  logic        blank_reg;
  logic        power_reg;

  wire link_err = mst_err_reg | mdt_err_reg;

  // faults first, then the phase or waiting state
  always_comb begin
    if (ctrl_reg[ring_sup_pkg::CTRL_PROC_NONE] || ctrl_reg[ring_sup_pkg::CTRL_PROC_FAIL])
      code_w = ring_sup_pkg::IND_HW_FAULT;
    else if (ctrl_reg[ring_sup_pkg::CTRL_CRC_FAIL]) code_w = ring_sup_pkg::IND_CRC_FAIL;
    else if (addr_zero)    code_w = ring_sup_pkg::IND_ADDR_ZERO;
    else if (ctrl_reg[ring_sup_pkg::CTRL_PARAM_BAD]) code_w = ring_sup_pkg::IND_PARAM_BAD;
    else if (ctrl_reg[ring_sup_pkg::CTRL_TEST]) code_w = ring_sup_pkg::IND_TEST;
    else if (inv_err_reg)  code_w = ring_sup_pkg::IND_INV_PHASE;
    else if (prog_err_reg) code_w = ring_sup_pkg::IND_PROG_ERR;
    else if (regr_err_reg) code_w = ring_sup_pkg::IND_REGR_ERR;
    else if (mst_err_reg)  code_w = ring_sup_pkg::IND_MST_ERR;
    else if (mdt_err_reg)  code_w = ring_sup_pkg::IND_MDT_ERR;
    else begin
      // a blocked advance leaves the state, so the last good phase stays shown
      unique case (state_reg)
        ring_sup_pkg::ST_WAIT: code_w = ring_sup_pkg::IND_WAIT_SYNC;
        ring_sup_pkg::ST_PH0:  code_w = ring_sup_pkg::IND_WAIT_01;
        ring_sup_pkg::ST_PH1:  code_w = ring_sup_pkg::IND_WAIT_12;
        ring_sup_pkg::ST_PH2:  code_w = ring_sup_pkg::IND_PH2;
        ring_sup_pkg::ST_PH3:  code_w = ring_sup_pkg::IND_PH3;
        ring_sup_pkg::ST_PH4:  code_w = ring_sup_pkg::IND_CYCLIC;
        default:               code_w = ring_sup_pkg::IND_WAIT_SYNC;
      endcase
    end
  end

  wire blink_tick = (blink_cnt_reg == 25'(BLINK_CYCLES - 1));
  wire flashing   = ctrl_reg[ring_sup_pkg::CTRL_PROC_FAIL] &
                    ~ctrl_reg[ring_sup_pkg::CTRL_PROC_NONE];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      blink_cnt_reg <= 25'h0000000;
      blink_reg     <= 1'b0;
      code_reg      <= ring_sup_pkg::IND_WAIT_SYNC;
      dp_reg        <= 1'b0;
      blank_reg     <= 1'b0;
      power_reg     <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_tick ? 25'h0000000 : blink_cnt_reg + 25'h0000001;
      if (blink_tick) blink_reg <= ~blink_reg;
      code_reg  <= code_w;
      dp_reg    <= rate_high;
      blank_reg <= flashing & blink_reg;
      power_reg <= (state_reg == ring_sup_pkg::ST_PH4) & ~link_err;
    end
  end

  assign ring_status_indicator = code_reg;
  assign ring_status_dp        = dp_reg;
  assign ring_status_blank     = blank_reg;
  assign power_stage_en        = power_reg;

  assign status_w = {11'h000, code_reg, 4'h0, rate_high, addr_zero, regr_err_reg,
                     prog_err_reg, inv_err_reg, mdt_err_reg, mst_err_reg, power_reg,
                     waiting, cur_num};

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_power_after_ph4: assert property (power_stage_en |-> $past(state_reg == ring_sup_pkg::ST_PH4))
    else $error("power enabled outside phase 4");
  // a reset in mid-run moves the state without any master request
  a_phase_one_step: assert property (resetn && $past(resetn) &&
    state_reg != $past(state_reg) && state_reg != ring_sup_pkg::ST_PH0 |->
    state_reg == $past(state_reg) + 3'h1)
    else $error("phase skipped");
  a_regr_holds: assert property (mst_v && !waiting && req_ph < cur_num && req_ph != 3'h0
    |=> $stable(state_reg)) else $error("state moved on a refused step back");
  a_block_ph3_bad: assert property (mst_v && state_reg == ring_sup_pkg::ST_PH2 &&
    req_ph == 3'h3 && bad3 != 16'h0000 |=> state_reg == ring_sup_pkg::ST_PH2 && list3_reg != 0)
    else $error("phase 3 entered with invalid parameters");
  a_block_ph4_bad: assert property (mst_v && state_reg == ring_sup_pkg::ST_PH3 &&
    req_ph == 3'h4 && bad4 != 16'h0000 |=> state_reg == ring_sup_pkg::ST_PH3 && list4_reg != 0)
    else $error("phase 4 entered with invalid parameters");
  a_mst_double_err: assert property (mon_on && ring_evt.mst_miss && !mst_v ##1
    (!mst_v && !ring_evt.mst_miss && mon_on)[*3] ##1 ring_evt.mst_miss && mon_on
    |=> mst_err_reg) else $error("double sync failure not flagged");
  a_mdt_err_cause: assert property ($rose(mdt_err_reg) |-> $past(mon_on) && $past(mdt_fail))
    else $error("data telegram error without cause");
  a_addr_zero_code: assert property (addr_zero && ctrl_reg[4:1] == 4'h0 |=>
    ring_status_indicator == ring_sup_pkg::IND_ADDR_ZERO)
    else $error("address zero not shown");
  // the synchronisers reset to the high rate, so the edges round a reset are skipped
  a_dp_follows_rate: assert property (resetn && $past(resetn) |->
    ring_status_dp == $past(rate_high))
    else $error("decimal point does not follow rate");
  // steady display wins when both processor faults are set
  a_blank_steady: assert property (ctrl_reg[ring_sup_pkg::CTRL_PROC_NONE] |=>
    !ring_status_blank) else $error("steady hardware fault flashes");
  a_power_drop_err: assert property (mst_err_reg || mdt_err_reg |=> !power_stage_en)
    else $error("power stays enabled with telegram error");
  a_wait_sync_code: assert property (waiting && !addr_zero && ctrl_reg == 5'h00 &&
    !inv_err_reg && !prog_err_reg && !regr_err_reg |=>
    ring_status_indicator == ring_sup_pkg::IND_WAIT_SYNC)
    else $error("wait for sync not shown");
  a_bus_one_wait: assert property (req && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not after one wait cycle");


  c_reach_cyclic: cover property (state_reg == ring_sup_pkg::ST_PH4);
  c_mdt_error:    cover property ($rose(mdt_err_reg));
  c_block_at_ph2: cover property (blocked && state_reg == ring_sup_pkg::ST_PH2);
  c_mst_error:    cover property ($rose(mst_err_reg));
  c_bus_read:     cover property (read && !waitrequest);

endmodule // ring_phase_status_supervisor

// *** pkg/ring_sup_pkg.sv ***
// constants, types and register map of the ring phase status supervisor
package ring_sup_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_HZ          = 100_000_000;
  localparam int BLINK_HALF_MS   = 250;
  localparam int BLINK_CYCLES    = BLINK_HALF_MS * (CLK_HZ / 1000);

  // ************************************************************
  // register map, byte addresses on the avalon slave
  // ************************************************************
  localparam int AW              = 6;
  localparam logic [5:0] OFS_CTRL    = 6'h00;
  localparam logic [5:0] OFS_STATUS  = 6'h04;
  localparam logic [5:0] OFS_PRESENT = 6'h08;
  localparam logic [5:0] OFS_INRANGE = 6'h0c;
  localparam logic [5:0] OFS_REQ3    = 6'h10;
  localparam logic [5:0] OFS_REQ4    = 6'h14;
  localparam logic [5:0] OFS_LIST3   = 6'h18;
  localparam logic [5:0] OFS_LIST4   = 6'h1c;

  // ctrl fields
  localparam int CTRL_TEST       = 0;
  localparam int CTRL_CRC_FAIL   = 1;
  localparam int CTRL_PARAM_BAD  = 2;
  localparam int CTRL_PROC_NONE  = 3;
  localparam int CTRL_PROC_FAIL  = 4;
  localparam int CTRL_ERR_CLR    = 5;
  localparam int CTRL_W          = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // status fields
  localparam int ST_PHASE_LSB    = 0;
  localparam int ST_WAIT_SYNC    = 3;
  localparam int ST_POWER_EN     = 4;
  localparam int ST_MST_ERR      = 5;
  localparam int ST_MDT_ERR      = 6;
  localparam int ST_INV_PHASE    = 7;
  localparam int ST_PROG_ERR     = 8;
  localparam int ST_REGR_ERR     = 9;
  localparam int ST_ADDR_ZERO    = 10;
  localparam int ST_RATE_HIGH    = 11;
  localparam int ST_CODE_LSB     = 16;

  // parameter check slots
  localparam int NSLOT             = 16;
  localparam logic [15:0] SLOT_RST = 16'h0000;
  localparam logic [15:0] REQ_RST  = 16'hffff;

  // ************************************************************
  // indicator codes, lower value wins nothing: priority is in logic
  // ************************************************************
  localparam logic [4:0] IND_HW_FAULT   = 5'h01;
  localparam logic [4:0] IND_CRC_FAIL   = 5'h02;
  localparam logic [4:0] IND_ADDR_ZERO  = 5'h03;
  localparam logic [4:0] IND_PARAM_BAD  = 5'h04;
  localparam logic [4:0] IND_TEST       = 5'h05;
  localparam logic [4:0] IND_INV_PHASE  = 5'h06;
  localparam logic [4:0] IND_PROG_ERR   = 5'h07;
  localparam logic [4:0] IND_REGR_ERR   = 5'h08;
  localparam logic [4:0] IND_MST_ERR    = 5'h09;
  localparam logic [4:0] IND_MDT_ERR    = 5'h0a;
  localparam logic [4:0] IND_WAIT_SYNC  = 5'h10;
  localparam logic [4:0] IND_WAIT_01    = 5'h11;
  localparam logic [4:0] IND_WAIT_12    = 5'h12;
  localparam logic [4:0] IND_PH2        = 5'h13;
  localparam logic [4:0] IND_PH3        = 5'h14;
  localparam logic [4:0] IND_CYCLIC     = 5'h15;

  localparam logic [2:0] PHASE_MAX = 3'h4;

  typedef enum logic [2:0] {
    ST_WAIT, ST_PH0, ST_PH1, ST_PH2, ST_PH3, ST_PH4
  } phase_state_t;

  // telegram events from the ring receiver, one-cycle pulses
  typedef struct packed {
    logic       mst_valid;
    logic [2:0] mst_phase;
    logic       mst_miss;
    logic       mdt_ok;
    logic       mdt_miss;
    logic       mdt_len_err;
    logic       mdt_crc_err;
  } ring_evt_t;

endpackage

// *** testbench/nc_master_model.sv ***
// ring master model: sends sync and data telegram events to the drive
`timescale 1ns/1ps

module nc_master_model (
  input  wire logic               clk_sys,  // drive clock
  output ring_sup_pkg::ring_evt_t ring_evt  // one-cycle event pulses
);
  initial ring_evt = '0;

  // gap sets how slowly the master moves on to its next telegram
  task automatic pulse(input ring_sup_pkg::ring_evt_t e, input int gap);
    @(posedge clk_sys);
    ring_evt <= e;
    @(posedge clk_sys);
    ring_evt <= '0;
    repeat (gap) @(posedge clk_sys);
  endtask

  task automatic sync(input logic [2:0] ph, input int gap);
    ring_sup_pkg::ring_evt_t e;
    e = '0;
    e.mst_valid = 1'b1;
    e.mst_phase = ph;
    pulse(e, gap);
  endtask

  // 0 sync missing, 1 data wrong length, 2 data bad checksum, 3 data missing, 4 good data
  task automatic fail(input int k);
    ring_sup_pkg::ring_evt_t e;
    e = '0;
    e.mst_miss = (k == 0);
    e.mdt_len_err = (k == 1);
    e.mdt_crc_err = (k == 2);
    e.mdt_miss = (k == 3);
    e.mdt_ok = (k == 4);
    pulse(e, 2);
  endtask
endmodule // nc_master_model

// *** testbench/tb_top.sv ***
// top testbench: bus master, read scoreboard and scenarios
`timescale 1ns/1ps

module tb_top;
  localparam int          BLINK = 8;
  localparam logic [31:0] MS    = 32'h001f0fff;
  localparam logic [31:0] MW    = 32'h001f0ff8;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  station_addr_pins = 8'hfa;
  logic        rate_select_switch = 1'b1;
  logic [4:0]  ring_status_indicator;
  logic        ring_status_dp, ring_status_blank, power_stage_en;
  ring_sup_pkg::ring_evt_t ring_evt;
  logic [63:0] exp_q[$];
  logic [4:0]  codes[5];
  logic [15:0] rnd;
  logic        b0;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;

  always #5 clk_sys = ~clk_sys;

  nc_master_model i_master (.clk_sys(clk_sys), .ring_evt(ring_evt));

  ring_phase_status_supervisor #(.BLINK_CYCLES(BLINK)) i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .ring_evt(ring_evt),
    .station_addr_pins(station_addr_pins), .rate_select_switch(rate_select_switch),
    .ring_status_indicator(ring_status_indicator), .ring_status_dp(ring_status_dp),
    .ring_status_blank(ring_status_blank), .power_stage_en(power_stage_en));

  // ************************************************************
  // reporting
  // ************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // a hang in the handshake ends here instead of running forever
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  // read data are checked in the cycle waitrequest is low; rdata_reg keeps them until the next access
  always @(posedge clk_sys) begin
    if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
      logic [63:0] n;
      n = exp_q.pop_front();
      chk($sformatf("rd %h", address), n[31:0], readdata & n[63:32]);
    end
  end

  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e & m});
    bus(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] st(input logic [4:0] c, input logic [11:0] b);
    return {11'h000, c, 4'h0, b};
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    codes = '{ring_sup_pkg::IND_TEST, ring_sup_pkg::IND_CRC_FAIL,
      ring_sup_pkg::IND_PARAM_BAD, ring_sup_pkg::IND_HW_FAULT, ring_sup_pkg::IND_HW_FAULT};
    void'($urandom(32'h3ae5b492));
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_WAIT_SYNC, 12'h808), MW);
    rd(ring_sup_pkg::OFS_REQ3, 32'h0000ffff, '1);
    wr(6'h23, 32'hffffffff);
    rd(6'h23, 32'h0, '1);
    rnd = (16'($urandom()) & 16'hffcf) | 16'h0001;
    wr(ring_sup_pkg::OFS_PRESENT, 32'h0);
    wr(ring_sup_pkg::OFS_INRANGE, 32'h0000ffff);
    wr(ring_sup_pkg::OFS_REQ3, {16'h0, rnd});
    wr(ring_sup_pkg::OFS_REQ4, 32'h00000030);
    i_master.sync(3'd0, 2);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_WAIT_01, 12'h800), MS);
    i_master.sync(3'd1, 0);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_WAIT_12, 12'h801), MS);
    i_master.sync(3'd2, 2);
    i_master.sync(3'd3, 2);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_PH2, 12'h802), MS);
    rd(ring_sup_pkg::OFS_LIST3, {16'h0, rnd}, '1);
    wr(ring_sup_pkg::OFS_PRESENT, 32'h0000ffcf);
    rd(ring_sup_pkg::OFS_LIST3, 32'h0, '1);
    i_master.sync(3'd3, 2);
    i_master.sync(3'd4, 2);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_PH3, 12'h803), MS);
    rd(ring_sup_pkg::OFS_LIST4, 32'h00000030, '1);
    wr(ring_sup_pkg::OFS_PRESENT, 32'h0000ffff);
    i_master.sync(3'd4, 2);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_CYCLIC, 12'h814), MS);
    chk("power_stage_en", 32'h1, {31'h0, power_stage_en});
    // a good data telegram between two failures clears the pending one
    i_master.fail(3);
    i_master.fail(4);
    i_master.fail(1);
    // a good sync between two misses must not count as a double failure
    i_master.fail(0);
    i_master.sync(3'd4, 0);
    i_master.fail(0);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_CYCLIC, 12'h814), MS);
    i_master.sync(3'd4, 0);
    i_master.fail(0);
    i_master.fail(0);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_MST_ERR, 12'h824), MS);
    i_master.fail(2);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_MST_ERR, 12'h864), MS);
    wr(ring_sup_pkg::OFS_CTRL, 32'h20);
    i_master.sync(3'd2, 2);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_REGR_ERR, 12'ha14), MS);
    wr(ring_sup_pkg::OFS_CTRL, 32'h20);
    i_master.sync(3'd5, 2);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_INV_PHASE, 12'h894), MS);
    wr(ring_sup_pkg::OFS_CTRL, 32'h20);
    i_master.sync(3'd0, 2);
    i_master.sync(3'd2, 2);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_PROG_ERR, 12'h900), MS);
    wr(ring_sup_pkg::OFS_CTRL, 32'h20);
    for (int i = 0; i < 5; i++) begin
      wr(ring_sup_pkg::OFS_CTRL, 32'h1 << i);
      rd(ring_sup_pkg::OFS_STATUS, {11'h0, codes[i], 16'h0}, 32'h001f0000);
    end
    b0 = ring_status_blank;
    repeat (BLINK) @(posedge clk_sys);
    chk("blank", {31'h0, ~b0}, {31'h0, ring_status_blank});
    wr(ring_sup_pkg::OFS_CTRL, 32'h18);
    repeat (BLINK) @(posedge clk_sys);
    chk("blank", 32'h0, {31'h0, ring_status_blank});
    wr(ring_sup_pkg::OFS_CTRL, 32'h03);
    rd(ring_sup_pkg::OFS_CTRL, 32'h03, '1);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_CRC_FAIL, 12'h800), MS);
    wr(ring_sup_pkg::OFS_CTRL, 32'h0);
    station_addr_pins <= 8'h00;
    rate_select_switch <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_ADDR_ZERO, 12'h400), MS);
    chk("dp", 32'h0, {31'h0, ring_status_dp});
    rate_select_switch <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("dp", 32'h1, {31'h0, ring_status_dp});
    i_master.fail(0);
    resetn <= 1'b0;
    @(posedge clk_sys);
    resetn <= 1'b1;
    station_addr_pins <= 8'h05;
    repeat (5) @(posedge clk_sys);
    rd(ring_sup_pkg::OFS_STATUS, st(ring_sup_pkg::IND_WAIT_SYNC, 12'h808), MW);
    complete_run();
  end
endmodule // tb_top
